// ===== core/rxpcs_pkg.sv
// Shared constants and types for the 100 Mb/s receive coding path
package rxpcs_pkg;
  // Clock rate and timing figures
  localparam int CLK_MHZ = 25;
  localparam int HOLD_US = 722;
  localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
  localparam int LINK_US = 395;
  localparam int LINK_CYC = LINK_US * CLK_MHZ;
  localparam int SD_QUAL_NS = 200;
  localparam int SD_QUAL_CYC = (SD_QUAL_NS * CLK_MHZ + 999) / 1000;
  localparam int IDLE_RUN_BITS = 58;
  localparam int LOCK_IDLES = 12;
  localparam int GRP_W = 5;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(LOCK_IDLES * GRP_W - 1);
  localparam logic [CNT_W-1:0] IDLE_RUN_LAST = CNT_W'(IDLE_RUN_BITS - 1);
  localparam logic [2:0] SD_QUAL_LAST = 3'(SD_QUAL_CYC - 1);
  // Descrambler key register, x^11 + x^9 + 1
  localparam int LFSR_W = 11;
  localparam int TAP_A = 10;
  localparam int TAP_B = 8;
  // Line symbol levels
  localparam int MLT_W = 2;
  localparam logic [MLT_W-1:0] MLT_ZERO = 2'h0;
  localparam logic [MLT_W-1:0] MLT_POS = 2'h1;
  localparam logic [MLT_W-1:0] MLT_NEG = 2'h3;
  // Code-groups, first bit on the line is the msb
  localparam logic [4:0] CG_IDLE = 5'h1F;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [9:0] CG_JK = {CG_J, CG_K};
  // Nibbles, alignment and counting
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [3:0] NIB_BAD_SSD = 4'hE;
  localparam logic [3:0] NIB_INVALID = 4'h0;
  localparam logic [2:0] PHASE_LAST = 3'h4;
  localparam logic [2:0] CHK_LAST = 3'h6;
  localparam logic [3:0] ONES_TWO_IDLES = 4'hA;
  localparam int FCC_W = 16;
  // Receive framing states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CHK = 4'h2,
    ST_FRAME = 4'h4,
    ST_BAD = 4'h8
  } rxpcs_state_t;
endpackage : rxpcs_pkg

// ===== core/rxpcs_descrambler.sv
// Serial descrambler with idle-based lock, line state monitor and hold timer
module rxpcs_descrambler #(
  parameter int HOLD_CYCLES = rxpcs_pkg::HOLD_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic enable,
  // Serial data
  input wire logic nrz_bit,
  output logic plain_bit,
  output logic locked
);
  import rxpcs_pkg::*;
  localparam int HW = $clog2(HOLD_CYCLES + 1);
  typedef struct packed {
    logic [LFSR_W-1:0] lfsr;
    logic [CNT_W-1:0] match_cnt;
    logic [CNT_W-1:0] run_cnt;
    logic [HW-1:0] hold_cnt;
    logic locked;
    logic plain;
  } rxpcs_descr_t;
  rxpcs_descr_t s_reg;
  rxpcs_descr_t s_next;
  logic key;
  logic restart;

  // Acquire on assumed idles, then free-run the key and police it
  always_comb begin
    s_next = s_reg;
    key = s_reg.lfsr[TAP_A] ^ s_reg.lfsr[TAP_B];
    restart = 1'b0;
    if (!enable) begin
      s_next = '0;
    end else if (!s_reg.locked) begin
      // Idle is all ones, so the key bit is the inverted line bit
      s_next.lfsr = {s_reg.lfsr[LFSR_W-2:0], ~nrz_bit};
      s_next.plain = 1'b0;
      if (key == ~nrz_bit) begin
        if (s_reg.match_cnt == LOCK_LAST) begin
          s_next.locked = 1'b1;
          s_next.hold_cnt = HW'(HOLD_CYCLES);
          s_next.run_cnt = '0;
        end else begin
          s_next.match_cnt = s_reg.match_cnt + 1'b1;
        end
      end else begin
        s_next.match_cnt = '0;
      end
    end else begin
      s_next.lfsr = {s_reg.lfsr[LFSR_W-2:0], key};
      s_next.plain = nrz_bit ^ key;
      // Line state monitor: a long run of ones is enough idle
      if (s_next.plain) begin
        if (s_reg.run_cnt == IDLE_RUN_LAST) begin
          restart = 1'b1;
        end else begin
          s_next.run_cnt = s_reg.run_cnt + 1'b1;
        end
      end else begin
        s_next.run_cnt = '0;
      end
      if (restart) begin
        s_next.hold_cnt = HW'(HOLD_CYCLES);
      end else if (s_reg.hold_cnt == HW'(1)) begin
        s_next = '0;
      end else begin
        s_next.hold_cnt = s_reg.hold_cnt - 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign plain_bit = s_reg.plain;
  assign locked = s_reg.locked;

  a_lock_after_idles: assert property (@(posedge clk) disable iff (rst)
    $rose(s_reg.locked) |->
      $past(s_reg.match_cnt) == LOCK_LAST && s_reg.hold_cnt == HW'(HOLD_CYCLES))
    else $error("lock without twelve idles");
  a_hold_expiry: assert property (@(posedge clk) disable iff (rst)
    (s_reg.locked && enable && s_reg.hold_cnt == HW'(1) && !restart) |=>
      !s_reg.locked && s_reg.lfsr == '0)
    else $error("hold timer expiry did not drop lock");
endmodule : rxpcs_descrambler

// ===== core/rxpcs_link_mon.sv
// Signal detect qualification and link integrity monitor
module rxpcs_link_mon #(
  parameter int LINK_CYCLES = rxpcs_pkg::LINK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Energy detect from the front end
  input wire logic sd_raw,
  // Status
  output logic sig_det,
  output logic link_up
);
  import rxpcs_pkg::*;
  localparam int LW = $clog2(LINK_CYCLES + 1);
  typedef struct packed {
    logic [2:0] qual_cnt;
    logic sig_det;
    logic [LW-1:0] up_cnt;
    logic link_up;
  } rxpcs_link_t;
  rxpcs_link_t s_reg;
  rxpcs_link_t s_next;

  // Link pulses are far shorter than the qualify time, so they never pass
  always_comb begin
    s_next = s_reg;
    if (!sd_raw) begin
      s_next = '0;
    end else begin
      if (s_reg.qual_cnt == SD_QUAL_LAST) begin
        s_next.sig_det = 1'b1;
      end else begin
        s_next.qual_cnt = s_reg.qual_cnt + 1'b1;
      end
      if (s_reg.sig_det && !s_reg.link_up) begin
        if (s_reg.up_cnt == LW'(LINK_CYCLES - 1)) begin
          s_next.link_up = 1'b1;
        end else begin
          s_next.up_cnt = s_reg.up_cnt + 1'b1;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sig_det = s_reg.sig_det;
  assign link_up = s_reg.link_up;

  a_link_wait: assert property (@(posedge clk) disable iff (rst)
    $rose(s_reg.link_up) |-> $past(s_reg.up_cnt) == LW'(LINK_CYCLES - 1) && $past(sd_raw))
    else $error("link up before signal detect time");
  a_short_pulse: assert property (@(posedge clk) disable iff (rst)
    $rose(s_reg.sig_det) |-> $past(sd_raw, 1) && $past(sd_raw, 2) && $past(sd_raw, 3))
    else $error("signal detect from short burst");
endmodule : rxpcs_link_mon

// ===== core/rxpcs_top.sv
// Receive coding path: line decode, descramble, align, decode, bad start handling
module rxpcs_top #(
  parameter int HOLD_CYCLES = rxpcs_pkg::HOLD_CYC,
  parameter int LINK_CYCLES = rxpcs_pkg::LINK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Line side, one equalized symbol per clock
  input wire logic [rxpcs_pkg::MLT_W-1:0] mlt_sym,
  input wire logic sd_raw,
  // Configuration
  input wire logic descr_bypass,
  // Nibble interface towards the MAC
  output logic rx_nib_en,
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic crs,
  // Status
  output logic sig_det,
  output logic link_up,
  output logic descr_locked,
  output logic [rxpcs_pkg::FCC_W-1:0] false_carrier_event_counter
);
  import rxpcs_pkg::*;

  typedef struct packed {
    logic [MLT_W-1:0] mlt_prev;
    logic nrzi;
    logic nrzi_prev;
    logic nrz;
    logic [9:0] win;
    logic [2:0] phase;
    logic [3:0] ones;
    logic [2:0] chk_cnt;
    logic [4:0] held;
    logic pre_pend;
    rxpcs_state_t st;
    logic nib_en;
    logic [3:0] rxd;
    logic rx_dv;
    logic rx_er;
    logic crs;
    logic [FCC_W-1:0] fcc;
  } rxpcs_top_t;

  rxpcs_top_t s_reg;
  rxpcs_top_t s_next;
  logic plain_bit;
  logic ser_bit;
  logic [9:0] win_n;
  logic [4:0] cur;
  logic tick;
  logic run_ok;
  logic [4:0] dec;

  // Group to {valid, nibble}; control and unused groups come back invalid
  function automatic logic [4:0] rxpcs_decode(input logic [4:0] cg);
    logic [4:0] r;
    r = {1'b0, NIB_INVALID};
    case (cg)
      5'h1E: r = 5'h10;
      5'h09: r = 5'h11;
      5'h14: r = 5'h12;
      5'h15: r = 5'h13;
      5'h0A: r = 5'h14;
      5'h0B: r = 5'h15;
      5'h0E: r = 5'h16;
      5'h0F: r = 5'h17;
      5'h12: r = 5'h18;
      5'h13: r = 5'h19;
      5'h16: r = 5'h1A;
      5'h17: r = 5'h1B;
      5'h1A: r = 5'h1C;
      5'h1B: r = 5'h1D;
      5'h1C: r = 5'h1E;
      5'h1D: r = 5'h1F;
      default: r = {1'b0, NIB_INVALID};
    endcase
    return r;
  endfunction : rxpcs_decode

  // Two-idle detector shared by the packet end and bad start exit
  function automatic logic rxpcs_two_idles(input logic [4:0] a, input logic [4:0] b);
    return (a == CG_IDLE) && (b == CG_IDLE);
  endfunction : rxpcs_two_idles

  // Descrambler with its own lock and hold timer
  rxpcs_descrambler #(
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_descr (
    .clk(clk),
    .rst(rst),
    .enable(link_up && !descr_bypass),
    .nrz_bit(s_reg.nrz),
    .plain_bit(plain_bit),
    .locked(descr_locked)
  );

  // Signal detect and link integrity
  rxpcs_link_mon #(
    .LINK_CYCLES(LINK_CYCLES)
  ) u_link (
    .clk(clk),
    .rst(rst),
    .sd_raw(sd_raw),
    .sig_det(sig_det),
    .link_up(link_up)
  );

  // Alignment input source; bypass skips the descrambler latency too
  assign ser_bit = descr_bypass ? s_reg.nrz : plain_bit;
  assign run_ok = link_up && (descr_bypass || descr_locked);
  assign win_n = {s_reg.win[8:0], ser_bit};
  assign cur = win_n[4:0];
  assign tick = (s_reg.phase == PHASE_LAST);
  assign dec = rxpcs_decode(s_reg.held);

  // Next-state logic for the whole receive path
  always_comb begin
    s_next = s_reg;
    s_next.nib_en = 1'b0;
    // Symbol level change toggles NRZI; NRZI change yields a one
    s_next.mlt_prev = mlt_sym;
    s_next.nrzi = s_reg.nrzi ^ (mlt_sym != s_reg.mlt_prev);
    s_next.nrzi_prev = s_reg.nrzi;
    s_next.nrz = s_reg.nrzi ^ s_reg.nrzi_prev;
    s_next.win = win_n;
    // Nibble-rate enable from the group phase divider
    s_next.phase = tick ? 3'h0 : s_reg.phase + 1'b1;
    case (s_reg.st)
      ST_IDLE: begin
        s_next.rx_dv = 1'b0;
        s_next.rx_er = 1'b0;
        s_next.crs = 1'b0;
        if (ser_bit) begin
          if (s_reg.ones != ONES_TWO_IDLES) begin
            s_next.ones = s_reg.ones + 1'b1;
          end
        end else begin
          s_next.ones = '0;
          // Only a zero after idles counts as a start of stream
          if (s_reg.ones == ONES_TWO_IDLES) begin
            s_next.st = ST_CHK;
            s_next.chk_cnt = '0;
            s_next.crs = 1'b1;
          end
        end
      end
      ST_CHK: begin
        s_next.chk_cnt = s_reg.chk_cnt + 1'b1;
        if (win_n == CG_JK) begin
          // Boundary fixed here and on the bad start branch below
          s_next.st = ST_FRAME;
          s_next.phase = 3'h0;
          s_next.rx_dv = 1'b1;
          s_next.rx_er = 1'b0;
          s_next.rxd = NIB_PRE;
          s_next.nib_en = 1'b1;
          s_next.pre_pend = 1'b1;
          s_next.held = CG_IDLE;
        end else if (s_reg.chk_cnt == CHK_LAST) begin
          s_next.st = ST_BAD;
          s_next.phase = 3'h0;
          s_next.fcc = s_reg.fcc + 1'b1;
          s_next.rx_er = 1'b1;
          s_next.rxd = NIB_BAD_SSD;
          s_next.nib_en = 1'b1;
          s_next.held = cur;
        end
      end
      ST_FRAME: begin
        if (tick) begin
          s_next.held = cur;
          if (s_reg.pre_pend) begin
            // One group of latency lets the pair become two nibbles
            s_next.pre_pend = 1'b0;
            s_next.rxd = NIB_PRE;
            s_next.nib_en = 1'b1;
          end else if ((s_reg.held == CG_T && cur == CG_R) ||
                       rxpcs_two_idles(s_reg.held, cur)) begin
            s_next.st = ST_IDLE;
            s_next.rx_dv = 1'b0;
            s_next.rx_er = 1'b0;
            s_next.crs = 1'b0;
            s_next.ones = '0;
          end else begin
            s_next.rxd = dec[3:0];
            s_next.rx_er = !dec[4];
            s_next.nib_en = 1'b1;
          end
        end
      end
      ST_BAD: begin
        if (tick) begin
          s_next.held = cur;
          if (rxpcs_two_idles(s_reg.held, cur)) begin
            s_next.st = ST_IDLE;
            s_next.rx_er = 1'b0;
            s_next.crs = 1'b0;
            s_next.ones = '0;
          end else begin
            s_next.rxd = NIB_BAD_SSD;
            s_next.rx_er = 1'b1;
            s_next.nib_en = 1'b1;
          end
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
    // Coding layers held quiet until link up and, if used, lock
    if (!run_ok) begin
      s_next.st = ST_IDLE;
      s_next.rx_dv = 1'b0;
      s_next.rx_er = 1'b0;
      s_next.crs = 1'b0;
      s_next.ones = '0;
      s_next.nib_en = 1'b0;
      s_next.pre_pend = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flops
  assign rx_nib_en = s_reg.nib_en;
  assign rxd = s_reg.rxd;
  assign rx_dv = s_reg.rx_dv;
  assign rx_er = s_reg.rx_er;
  assign crs = s_reg.crs;
  assign false_carrier_event_counter = s_reg.fcc;

  // Checks on the receive path
  a_nrzi_decode: assert property (@(posedge clk) disable iff (rst)
    $past(!rst, 4) |-> s_reg.nrz == ($past(mlt_sym, 2) != $past(mlt_sym, 3)))
    else $error("line change not decoded as one");
  a_fcc_count: assert property (@(posedge clk) disable iff (rst)
    (s_reg.st == ST_BAD && $past(s_reg.st) != ST_BAD) |->
      s_reg.fcc == $past(s_reg.fcc) + 1'b1)
    else $error("false carrier count not bumped once");
  a_fcc_only_bad: assert property (@(posedge clk) disable iff (rst)
    (s_reg.fcc != $past(s_reg.fcc)) |-> s_reg.st == ST_BAD && $past(s_reg.st) == ST_CHK)
    else $error("false carrier count moved without bad start");
  a_bad_nibble: assert property (@(posedge clk) disable iff (rst)
    (s_reg.st == ST_BAD && s_reg.nib_en) |-> s_reg.rx_er && s_reg.rxd == NIB_BAD_SSD && s_reg.crs)
    else $error("bad start nibble wrong");
  a_preamble_pair: assert property (@(posedge clk) disable iff (rst)
    $rose(s_reg.rx_dv) |-> s_reg.rxd == NIB_PRE && s_reg.nib_en ##5
      ((s_reg.rxd == NIB_PRE && s_reg.nib_en) || !s_reg.rx_dv))
    else $error("start pair not replaced by two preamble nibbles");
  a_bad_exit: assert property (@(posedge clk) disable iff (rst)
    ($past(s_reg.st) == ST_BAD && s_reg.st == ST_IDLE && run_ok) |->
      !s_reg.rx_er && !s_reg.crs && $past(cur) == CG_IDLE)
    else $error("bad start exit without idles");
  a_gate_link: assert property (@(posedge clk) disable iff (rst)
    !$past(run_ok) |-> !s_reg.rx_dv && !s_reg.crs && !s_reg.nib_en)
    else $error("receive active without link");
endmodule : rxpcs_top

// ===== bench/rxpcs_line_model.sv
// Line partner: sends code-groups as scrambled MLT-3 symbols, idles when nothing queued
module rxpcs_line_model (
  // Clock
  input wire logic clk,
  // Scrambling on
  input wire logic scram,
  // Line side
  output logic [rxpcs_pkg::MLT_W-1:0] mlt_sym,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  import rxpcs_pkg::*;
  logic [4:0] q[$];
  logic [4:0] grp = CG_IDLE;
  logic from_q = 1'b0;
  int left = 0;
  logic [10:0] key = 11'h5A3;
  logic [1:0] lvl = 2'h0;
  logic b;
  logic k;

  // Queue one group for the line
  task automatic send(input logic [4:0] g);
    q.push_back(g);
    // Busy at once, so a waiter in the same time step never sees a stale idle
    busy = 1'b1;
  endtask : send

  initial begin
    mlt_sym = MLT_ZERO;
    busy = 1'b0;
  end

  // One bit per falling edge, msb of a group first; idle fill keeps lock alive
  always @(negedge clk) begin
    if (left == 0) begin
      from_q = q.size() > 0;
      grp = from_q ? q.pop_front() : CG_IDLE;
      left = 5;
    end
    b = grp[left-1];
    left--;
    k = key[10] ^ key[8];
    key = {key[9:0], k};
    b = scram ? (b ^ k) : b;
    lvl = b ? lvl + 2'h1 : lvl;
    mlt_sym = (lvl == 2'h1) ? MLT_POS : (lvl == 2'h3) ? MLT_NEG : MLT_ZERO;
    busy = (q.size() > 0) || (from_q && left != 0);
  end
endmodule : rxpcs_line_model

// ===== bench/fast_ethernet_rx_pcs_tb_top.sv
// Self-checking bench for the receive coding path
module fast_ethernet_rx_pcs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rxpcs_pkg::*;
  localparam int HOLD = 200;
  localparam int LINK = 20;
  localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic clk = 1'b0;
  logic rst;
  logic sd_raw;
  logic descr_bypass;
  logic [MLT_W-1:0] mlt_sym;
  logic line_busy;
  logic rx_nib_en;
  logic [3:0] rxd;
  logic rx_dv;
  logic rx_er;
  logic crs;
  logic sig_det;
  logic link_up;
  logic descr_locked;
  logic [FCC_W-1:0] false_carrier_event_counter;
  logic [4:0] nq[$];
  logic [1:0] seen = 2'h0;
  int checks = 0;
  int n_fail = 0;
  int exp_fcc = 0;

  rxpcs_top #(.HOLD_CYCLES(HOLD), .LINK_CYCLES(LINK)) rxpcs_top_i (.clk(clk), .rst(rst),
    .mlt_sym(mlt_sym), .sd_raw(sd_raw), .descr_bypass(descr_bypass), .rx_nib_en(rx_nib_en),
    .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs), .sig_det(sig_det), .link_up(link_up),
    .descr_locked(descr_locked), .false_carrier_event_counter(false_carrier_event_counter));

  rxpcs_line_model rxpcs_line_model_i (.clk(clk), .scram(~descr_bypass), .mlt_sym(mlt_sym),
    .busy(line_busy));

  // 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end

  // Nibble capture at mid-cycle, error flag kept; valid and carrier remembered
  always @(negedge clk) begin
    if (rx_nib_en === 1'b1) nq.push_back({rx_er, rxd});
    seen = seen | {rx_dv === 1'b1, crs === 1'b1};
  end

  task automatic test_done();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // A wait that runs out ends the run
  task automatic timeout(input string what);
    n_fail++;
    $display("wrong value %s expected done seen timeout", what);
    test_done();
  endtask : timeout

  task automatic wait_lock(input logic v, output int n);
    n = 0;
    while (descr_locked !== v) begin
      @(negedge clk);
      n++;
      if (n > 3000) timeout("descr_locked");
    end
  endtask : wait_lock

  // Line drained, then carrier and valid must fall
  task automatic wait_done();
    int i;
    i = 0;
    while (line_busy !== 1'b0 || crs !== 1'b0 || rx_dv !== 1'b0) begin
      @(negedge clk);
      i++;
      if (i > 3000) timeout("frame end");
    end
  endtask : wait_done

  // Sends groups after two idles, compares the leading nibbles; exact also checks the count
  task automatic run_frame(input logic [4:0] g[$], input logic [4:0] e[$], input bit exact);
    nq = {};
    seen = 2'h0;
    rxpcs_line_model_i.send(CG_IDLE);
    rxpcs_line_model_i.send(CG_IDLE);
    foreach (g[i]) rxpcs_line_model_i.send(g[i]);
    wait_done();
    if (exact) chk("nibble count", 16'(e.size()), 16'(nq.size()));
    if (!exact) chk("enough nibbles", 16'h1, 16'(nq.size() >= e.size()));
    foreach (e[i]) if (i < nq.size()) chk("nibble", 16'(e[i]), 16'(nq[i]));
    chk("rx_er after frame", 16'h0, 16'(rx_er));
  endtask : run_frame

  task automatic t_reset();
    chk("outputs in reset", 16'h0, 16'({rx_nib_en, rxd, rx_dv, rx_er, crs, sig_det, link_up}));
    chk("lock and counter in reset", 16'h0, false_carrier_event_counter | 16'(descr_locked));
  endtask : t_reset

  // Short energy bursts like link pulses never qualify
  task automatic t_pulses();
    logic seen;
    seen = 1'b0;
    repeat (6) begin
      sd_raw = 1'b1;
      repeat (3) @(negedge clk);
      sd_raw = 1'b0;
      repeat (20) begin
        @(negedge clk);
        seen = seen | (sig_det !== 1'b0);
      end
    end
    chk("sig_det on pulses", 16'h0, 16'(seen));
  endtask : t_pulses

  task automatic t_link();
    int n;
    n = 0;
    sd_raw = 1'b1;
    while (link_up !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 200) timeout("link_up");
    end
    chk("link_up delay in range", 16'h1, 16'(n >= 5 + LINK && n <= 5 + LINK + 6));
    chk("sig_det with link", 16'h1, 16'(sig_det));
  endtask : t_link

  // Every data code, preamble substitution, end on end pair
  task automatic t_packet();
    logic [4:0] g[$];
    logic [4:0] e[$];
    g = {CG_J, CG_K};
    e = {5'h05, 5'h05};
    for (int d = 0; d < 16; d++) begin
      g.push_back(ENC[d]);
      e.push_back(5'(d));
    end
    g.push_back(CG_T);
    g.push_back(CG_R);
    run_frame(g, e, 1'b1);
    chk("rx_dv and crs seen", 16'h3, 16'(seen));
  endtask : t_packet

  task automatic t_idle_end();
    run_frame({CG_J, CG_K, ENC[3], ENC[7], ENC[9]},
      {5'h05, 5'h05, 5'h03, 5'h07, 5'h09}, 1'b1);
  endtask : t_idle_end

  task automatic t_ctrl_in_data();
    run_frame({CG_J, CG_K, ENC[3], CG_J, ENC[4], CG_T, CG_R},
      {5'h05, 5'h05, 5'h03, 5'h10}, 1'b0);
  endtask : t_ctrl_in_data

  task automatic t_bad_ssd();
    run_frame({ENC[4], ENC[5], ENC[6], ENC[7]},
      {5'h1E, 5'h1E, 5'h1E}, 1'b0);
    chk("carrier without valid", 16'h1, 16'(seen));
    exp_fcc++;
    chk("false carrier count", 16'(exp_fcc), false_carrier_event_counter);
  endtask : t_bad_ssd

  // Idles keep restarting the hold timer
  task automatic t_hold_keep();
    logic lost;
    lost = 1'b0;
    repeat (3 * HOLD) begin
      @(negedge clk);
      lost = lost | (descr_locked !== 1'b1);
    end
    chk("lock kept on idles", 16'h0, 16'(lost));
  endtask : t_hold_keep

  // No idles for longer than the hold time: lock drops, then comes back on idles
  task automatic t_hold_drop();
    int n;
    repeat (50) rxpcs_line_model_i.send(ENC[0]);
    wait_lock(1'b0, n);
    chk("hold time before drop", 16'h1, 16'(n >= HOLD && n <= HOLD + 40));
    exp_fcc++;
    chk("false carrier count", 16'(exp_fcc), false_carrier_event_counter);
    wait_lock(1'b1, n);
    chk("relocked", 16'h1, 16'(descr_locked));
  endtask : t_hold_drop

  initial begin
    int n;
    rst = 1'b1;
    sd_raw = 1'b0;
    descr_bypass = 1'b1;
    repeat (5) @(negedge clk);
    t_reset();
    rst = 1'b0;
    t_pulses();
    t_link();
    // Bypass path: groups straight from the line decoder
    t_packet();
    t_idle_end();
    t_ctrl_in_data();
    t_bad_ssd();
    t_bad_ssd();
    // Descrambled path
    descr_bypass = 1'b0;
    wait_lock(1'b1, n);
    chk("lock on idles", 16'h1, 16'(n >= 60 && n < 3000));
    t_packet();
    t_hold_keep();
    t_hold_drop();
    t_bad_ssd();
    test_done();
  end
endmodule : fast_ethernet_rx_pcs_tb_top
